// File: dio_wdog_regs.v
// register bank of a twelve-channel discrete i/o module with port watchdogs
// assumes a register request port fed by the network side, one request at a
// time, and pins sampled synchronously to sys_clk
//
// Behaviour
// [RULE1] coil address n controls output channel n through bit n
// [RULE2] coil one turns the output on, zero turns it off
// [RULE3] unused coil word bits read back as zero
// [RULE4] reset clears all coils, outputs off, nothing kept across reset
// [RULE5] coil readback gives commanded gate drive, not the pin level
// [RULE6] input address n reports input channel n at bit n, read only
// [RULE7] input status reads one when the active-low input is low
// [RULE8] tandem variant reports the paired output pin level instead
// [RULE9] status bit 14 shows identify-blink mode
// [RULE10] status bit 13 shows default mode
// [RULE11] status bits 2..0 show pending watchdog fault per port
// [RULE12] status bits 15 and 12..3 read zero
// [RULE13] each port has its own watchdog time, 1 to 65534 seconds
// [RULE14] watchdog time 0 or 65535 disables that port timer
// [RULE15] timeout state low four bits drive port outputs on timeout
// [RULE16] timeout state 65535, the default, leaves outputs unchanged
// [RULE17] pending timeout cleared only by same-port channel access or reset
// [RULE18] holding register writes act immediately
// [RULE19] clearing a timeout keeps outputs at timeout values
// [RULE20] client toggles identify mode via an outside identify register
// [RULE21] seconds since last port access reach time, fault and apply state
`timescale 1ns/10ps
`default_nettype none
`include "dio_defs.vh"

module dio_wdog_regs #(
  parameter TANDEM = 1,
  parameter TICKS_PER_SEC = `DIO_SECOND_NS / `DIO_CLK_PERIOD_NS,
  parameter TICK_W = 28
) (
  // clock and reset
  input wire sys_clk,
  input wire reset_n,
  input wire swReset,
  // register request
  input wire reqValid,
  input wire reqWrite,
  input wire [1:0] reqSpace,
  input wire [15:0] reqAddr,
  input wire [15:0] reqWdata,
  // register answer
  output reg respValid,
  output reg respError,
  output reg [15:0] respData,
  // pins
  input wire [`DIO_NUM_CH-1:0] inPins,
  input wire [`DIO_NUM_CH-1:0] fbPins,
  output reg [`DIO_NUM_CH-1:0] gateDrive,
  // module mode levels
  input wire identifyBlink,
  input wire defaultMode,
  // fault flags
  output reg [`DIO_NUM_PORTS-1:0] portFault
);

  localparam [31:0] TICK_LAST_FULL = TICKS_PER_SEC - 1;
  localparam [TICK_W-1:0] TICK_LAST = TICK_LAST_FULL[TICK_W-1:0];
  localparam [TICK_W-1:0] TICK_ONE = {{(TICK_W-1){1'b0}}, 1'b1};

  // holding registers
  reg [15:0] wdTime0;
  reg [15:0] wdTime1;
  reg [15:0] wdTime2;
  reg [15:0] tosState0;
  reg [15:0] tosState1;
  reg [15:0] tosState2;

  // one-second timebase
  reg [TICK_W-1:0] tickCnt;
  reg secTick;

  // decode results
  reg [`DIO_NUM_PORTS-1:0] portHit;
  reg [15:0] next_respData;
  reg next_respError;
  reg [15:0] statusWord;
  reg [`DIO_NUM_CH-1:0] inStatus;

  wire [`DIO_NUM_PORTS-1:0] expire;
  wire reqChan;
  wire [3:0] reqBit;

  // port number owning a channel address
  function [1:0] portOf;
    input [15:0] addr;
    begin
      portOf = addr[3:2];
    end
  endfunction

  // channel address in range
  function chanOk;
    input [15:0] addr;
    begin
      chanOk = (addr >= `DIO_CH_FIRST) && (addr <= `DIO_CH_LAST);
    end
  endfunction

  // single bit of a channel word at its own position
  function [15:0] chanWord;
    input [`DIO_NUM_CH-1:0] bits;
    input [3:0] ch;
    begin
      chanWord = `DIO_WORD_ZERO;
      chanWord[ch] = bits[ch];
    end
  endfunction

  assign reqChan = chanOk(reqAddr);
  assign reqBit = reqAddr[3:0];

  // seconds timebase
  always @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      tickCnt <= {TICK_W{1'b0}};
      secTick <= 1'b0;
    end else if (swReset) begin
      tickCnt <= {TICK_W{1'b0}};
      secTick <= 1'b0;
    end else if (tickCnt >= TICK_LAST) begin
      tickCnt <= {TICK_W{1'b0}};
      secTick <= 1'b1;
    end else begin
      tickCnt <= tickCnt + TICK_ONE;
      secTick <= 1'b0;
    end
  end

  // input status source
  always @* begin
    // [RULE8] tandem feedback from output pins
    if (TANDEM != 0) begin
      inStatus = ~fbPins;
    end else begin
      // [RULE7] active-low inputs read one
      inStatus = ~inPins;
    end
  end

  // module status word
  always @* begin
    // [RULE12] unused bits stay zero
    statusWord = `DIO_WORD_ZERO;
    // [RULE9] identify-blink flag
    statusWord[`DIO_STAT_IDENT_BIT] = identifyBlink;
    // [RULE10] default mode flag
    statusWord[`DIO_STAT_DEFAULT_BIT] = defaultMode;
    // [RULE11] pending port faults
    statusWord[`DIO_STAT_FAULT_LSB +: `DIO_NUM_PORTS] = portFault;
  end

  // request decode
  always @* begin
    portHit = {`DIO_NUM_PORTS{1'b0}};
    next_respData = `DIO_WORD_ZERO;
    next_respError = 1'b0;
    if (reqValid) begin
      case (reqSpace)
        `DIO_SPACE_COIL: begin
          if (reqChan) begin
            portHit[portOf(reqAddr)] = 1'b1;
            // [RULE5] readback of commanded drive
            // [RULE3] other bits read zero
            if (!reqWrite) begin
              next_respData = chanWord(gateDrive, reqBit);
            end
          end else begin
            next_respError = 1'b1;
          end
        end
        `DIO_SPACE_INSTAT: begin
          // [RULE6] read-only input channels
          if (reqChan && !reqWrite) begin
            portHit[portOf(reqAddr)] = 1'b1;
            next_respData = chanWord(inStatus, reqBit);
          end else begin
            next_respError = 1'b1;
          end
        end
        `DIO_SPACE_INREG: begin
          if ((reqAddr == `DIO_INREG_STATUS) && !reqWrite) begin
            next_respData = statusWord;
          end else begin
            next_respError = 1'b1;
          end
        end
        `DIO_SPACE_HOLD: begin
          case (reqAddr)
            `DIO_HOLD_WDT0: next_respData = wdTime0;
            `DIO_HOLD_WDT1: next_respData = wdTime1;
            `DIO_HOLD_WDT2: next_respData = wdTime2;
            `DIO_HOLD_TOS0: next_respData = tosState0;
            `DIO_HOLD_TOS1: next_respData = tosState1;
            `DIO_HOLD_TOS2: next_respData = tosState2;
            default: next_respError = 1'b1;
          endcase
          if (reqWrite) begin
            next_respData = `DIO_WORD_ZERO;
          end
        end
        default: begin
          next_respError = 1'b1;
        end
      endcase
    end
  end

  // answer registers
  always @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      respValid <= 1'b0;
      respError <= 1'b0;
      respData <= `DIO_WORD_ZERO;
    end else if (swReset) begin
      respValid <= 1'b0;
      respError <= 1'b0;
      respData <= `DIO_WORD_ZERO;
    end else begin
      respValid <= reqValid;
      respError <= next_respError;
      respData <= next_respData;
    end
  end

  // holding register writes
  always @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      wdTime0 <= `DIO_WDT_RESET;
      wdTime1 <= `DIO_WDT_RESET;
      wdTime2 <= `DIO_WDT_RESET;
      tosState0 <= `DIO_TOS_RESET;
      tosState1 <= `DIO_TOS_RESET;
      tosState2 <= `DIO_TOS_RESET;
    end else if (swReset) begin
      wdTime0 <= `DIO_WDT_RESET;
      wdTime1 <= `DIO_WDT_RESET;
      wdTime2 <= `DIO_WDT_RESET;
      tosState0 <= `DIO_TOS_RESET;
      tosState1 <= `DIO_TOS_RESET;
      tosState2 <= `DIO_TOS_RESET;
    end else if (reqValid && reqWrite && (reqSpace == `DIO_SPACE_HOLD)) begin
      // [RULE18] stored value used next cycle
      // [RULE13] one time register per port
      case (reqAddr)
        `DIO_HOLD_WDT0: wdTime0 <= reqWdata;
        `DIO_HOLD_WDT1: wdTime1 <= reqWdata;
        `DIO_HOLD_WDT2: wdTime2 <= reqWdata;
        `DIO_HOLD_TOS0: tosState0 <= reqWdata;
        `DIO_HOLD_TOS1: tosState1 <= reqWdata;
        `DIO_HOLD_TOS2: tosState2 <= reqWdata;
        default: tosState2 <= tosState2;
      endcase
    end
  end

  // port watchdog timers
  dio_port_timer timer0 (
    .sys_clk(sys_clk),
    .reset_n(reset_n),
    .swReset(swReset),
    .secTick(secTick),
    .limit(wdTime0),
    .kick(portHit[0]),
    .hold(portFault[0]),
    .expire(expire[0])
  );

  dio_port_timer timer1 (
    .sys_clk(sys_clk),
    .reset_n(reset_n),
    .swReset(swReset),
    .secTick(secTick),
    .limit(wdTime1),
    .kick(portHit[1]),
    .hold(portFault[1]),
    .expire(expire[1])
  );

  dio_port_timer timer2 (
    .sys_clk(sys_clk),
    .reset_n(reset_n),
    .swReset(swReset),
    .secTick(secTick),
    .limit(wdTime2),
    .kick(portHit[2]),
    .hold(portFault[2]),
    .expire(expire[2])
  );

  // fault flags, a timeout beats a same-cycle clear
  always @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      portFault <= {`DIO_NUM_PORTS{1'b0}};
    end else if (swReset) begin
      portFault <= {`DIO_NUM_PORTS{1'b0}};
    end else begin
      // [RULE17] clear by port access only
      portFault <= expire | (portFault & ~portHit);
    end
  end

  // coil drive: client writes, then timeout states on top
  always @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      // [RULE4] all outputs off
      gateDrive <= `DIO_COIL_RESET;
    end else if (swReset) begin
      gateDrive <= `DIO_COIL_RESET;
    end else begin
      // [RULE1] bit n of the word at address n
      // [RULE2] one on, zero off
      if (reqValid && reqWrite && (reqSpace == `DIO_SPACE_COIL) && reqChan) begin
        gateDrive[reqBit] <= reqWdata[reqBit];
      end
      // [RULE15] apply timeout state bits
      // [RULE16] keep code leaves outputs
      // [RULE19] no restore on fault clear
      if (expire[0] && (tosState0 != `DIO_TOS_KEEP)) begin
        gateDrive[3:0] <= tosState0[3:0];
      end
      if (expire[1] && (tosState1 != `DIO_TOS_KEEP)) begin
        gateDrive[7:4] <= tosState1[3:0];
      end
      if (expire[2] && (tosState2 != `DIO_TOS_KEEP)) begin
        gateDrive[11:8] <= tosState2[3:0];
      end
    end
  end

endmodule
`default_nettype wire

// File: dio_defs.vh
// named constants for the discrete i/o register bank and its port watchdogs
// assumes nothing; included by dio_port_timer.v and dio_wdog_regs.v
`ifndef DIO_DEFS_VH
`define DIO_DEFS_VH

// register spaces selected by reqSpace
`define DIO_SPACE_COIL 2'h0
`define DIO_SPACE_INSTAT 2'h1
`define DIO_SPACE_INREG 2'h2
`define DIO_SPACE_HOLD 2'h3

// channel and port geometry
`define DIO_NUM_CH 12
`define DIO_CH_PER_PORT 4
`define DIO_NUM_PORTS 3

// addresses inside each space
`define DIO_CH_FIRST 16'h0000
`define DIO_CH_LAST 16'h000b
`define DIO_INREG_STATUS 16'h0000
`define DIO_HOLD_WDT0 16'h0000
`define DIO_HOLD_WDT1 16'h0001
`define DIO_HOLD_WDT2 16'h0002
`define DIO_HOLD_TOS0 16'h0003
`define DIO_HOLD_TOS1 16'h0004
`define DIO_HOLD_TOS2 16'h0005

// reset values and special codes
`define DIO_COIL_RESET 12'h000
`define DIO_WDT_RESET 16'h0000
`define DIO_WDT_OFF_ZERO 16'h0000
`define DIO_WDT_OFF_ALL 16'hffff
`define DIO_TOS_RESET 16'hffff
`define DIO_TOS_KEEP 16'hffff
`define DIO_WORD_ZERO 16'h0000

// module status word fields
`define DIO_STAT_IDENT_BIT 14
`define DIO_STAT_DEFAULT_BIT 13
`define DIO_STAT_FAULT_LSB 0

// timing
`define DIO_CLK_PERIOD_NS 5
`define DIO_SECOND_NS 1000000000

`endif

// File: dio_port_timer.v
// one port watchdog: counts seconds since the last access to its port
// assumes a one-cycle secTick per second and a kick on every port access
`timescale 1ns/10ps
`default_nettype none
`include "dio_defs.vh"

module dio_port_timer (
  // clock and reset
  input wire sys_clk,
  input wire reset_n,
  input wire swReset,
  // timebase and control
  input wire secTick,
  input wire [15:0] limit,
  input wire kick,
  input wire hold,
  // timeout event
  output reg expire
);

  reg [15:0] secCount;
  wire [16:0] nextCount;
  wire enabled;

  assign nextCount = {1'b0, secCount} + 17'h00001;
  // [RULE14] zero or all ones disable
  assign enabled = (limit != `DIO_WDT_OFF_ZERO) && (limit != `DIO_WDT_OFF_ALL);

  always @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      secCount <= `DIO_WORD_ZERO;
      expire <= 1'b0;
    end else if (swReset || kick || !enabled) begin
      secCount <= `DIO_WORD_ZERO;
      expire <= 1'b0;
    end else if (hold) begin
      expire <= 1'b0;
    end else if (secTick) begin
      // [RULE21] count reaches programmed time
      if (nextCount >= {1'b0, limit}) begin
        secCount <= `DIO_WORD_ZERO;
        expire <= 1'b1;
      end else begin
        secCount <= nextCount[15:0];
        expire <= 1'b0;
      end
    end else begin
      expire <= 1'b0;
    end
  end

endmodule
`default_nettype wire

// File: dio_client.sv
// register client standing in for the network side of the bank
// assumes the one-cycle request strobe and one-cycle answer of the bank
`timescale 1ns/10ps
`default_nettype none
module dio_client (
  // clock
  input wire logic sys_clk,
  // request
  output logic reqValid,
  output logic reqWrite,
  output logic [1:0] reqSpace,
  output logic [15:0] reqAddr,
  output logic [15:0] reqWdata,
  // answer
  input wire logic respValid,
  input wire logic respError,
  input wire logic [15:0] respData
);
  initial begin
    reqValid = 1'b0;
    reqWrite = 1'b0;
    reqSpace = 2'h0;
    reqAddr = 16'h0000;
    reqWdata = 16'h0000;
  end
  // one request, answer taken at the edge after it; fields scrambled on release
  task automatic xfer(input logic w, input logic [1:0] sp, input logic [15:0] a,
                      input logic [15:0] wd, output logic [15:0] rd, output logic er);
    @(posedge sys_clk);
    #1;
    reqValid = 1'b1;
    reqWrite = w;
    reqSpace = sp;
    reqAddr = a;
    reqWdata = wd;
    @(posedge sys_clk);
    #1;
    rd = respData;
    er = (respValid === 1'b1) ? respError : 1'bx;
    reqValid = 1'b0;
    reqWrite = ~w;
    reqSpace = ~sp;
    reqAddr = ~a;
    reqWdata = ~wd;
  endtask
endmodule
`default_nettype wire

// File: dio_wdog_regs_chk.sv
// timing checks on the register bank ports
// assumes the bind hands over TANDEM, which picks the input status source
`timescale 1ns/10ps
`default_nettype none
module dio_wdog_regs_chk #(parameter int TANDEM = 1) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic swReset,
  // request and answer
  input wire logic reqValid,
  input wire logic reqWrite,
  input wire logic [1:0] reqSpace,
  input wire logic [15:0] reqAddr,
  input wire logic respValid,
  input wire logic respError,
  input wire logic [15:0] respData,
  // pins and levels
  input wire logic [11:0] inPins,
  input wire logic [11:0] fbPins,
  input wire logic [11:0] gateDrive,
  input wire logic identifyBlink,
  input wire logic defaultMode,
  input wire logic [2:0] portFault
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  logic p0Acc;
  assign p0Acc = reqValid && reqSpace < 2'h2 && reqAddr < 16'h0004 && !(reqWrite && reqSpace == 2'h1);
  sequence s_coilRd;
    reqValid && !reqWrite && reqSpace == 2'h0 && reqAddr < 16'h000c;
  endsequence
  sequence s_inRd;
    reqValid && !reqWrite && reqSpace == 2'h1 && reqAddr < 16'h000c;
  endsequence
  sequence s_p0Clear;
    portFault[0] && p0Acc && !swReset;
  endsequence
  property p_answer; reqValid |=> respValid; endproperty
  property p_quiet; !reqValid |=> !respValid; endproperty
  property p_coilRead;
    s_coilRd |=> respData == ({4'h0, $past(gateDrive)} & (16'h0001 << $past(reqAddr)));
  endproperty
  property p_inRead;
    s_inRd |=> respData == ({4'h0, (TANDEM != 0) ? ~$past(fbPins) : ~$past(inPins)}
      & (16'h0001 << $past(reqAddr)));
  endproperty
  property p_status;
    reqValid && !reqWrite && reqSpace == 2'h2 && reqAddr == 16'h0000 |=>
      respData == {1'b0, $past(identifyBlink), $past(defaultMode), 10'h000, $past(portFault)};
  endproperty
  property p_roWrite; reqValid && reqWrite && reqSpace == 2'h1 |=> respError && respData == 16'h0000;
  endproperty
  property p_sticky; portFault[0] && !p0Acc && !swReset |=> portFault[0]; endproperty
  property p_clear; s_p0Clear |=> !portFault[0]; endproperty
  property p_swReset; swReset |=> gateDrive == 12'h000 && portFault == 3'h0; endproperty
  a_answer: assert property (p_answer) else $error("no answer after request");
  a_quiet: assert property (p_quiet) else $error("answer without request");
  a_coilRead: assert property (p_coilRead) else $error("coil readback wrong");
  a_inRead: assert property (p_inRead) else $error("input status wrong");
  a_status: assert property (p_status) else $error("status word wrong");
  a_roWrite: assert property (p_roWrite) else $error("input write not refused");
  a_sticky: assert property (p_sticky) else $error("fault dropped alone");
  a_clear: assert property (p_clear) else $error("fault not cleared");
  a_swReset: assert property (p_swReset) else $error("soft reset incomplete");
endmodule
bind dio_wdog_regs dio_wdog_regs_chk #(.TANDEM(TANDEM)) chk_u (.sys_clk, .reset_n, .swReset,
  .reqValid, .reqWrite, .reqSpace, .reqAddr, .respValid, .respError, .respData, .inPins,
  .fbPins, .gateDrive, .identifyBlink, .defaultMode, .portFault);
`default_nettype wire

// File: tb_dio_wdog_regs.sv
// self-checking bench for the register bank with port watchdogs
// assumes the client model drives all requests; one second is TPS cycles
`timescale 1ns/10ps
`default_nettype none
module tb_dio_wdog_regs;
  localparam int TPS = 20;
  logic sys_clk, reset_n, swReset, identifyBlink, defaultMode;
  logic reqValid, reqWrite, respValid, respError, er;
  logic [1:0] reqSpace;
  logic [15:0] reqAddr, reqWdata, respData, respData0, rd, wd;
  logic [11:0] inPins, fbPins, gateDrive, mGate;
  logic [2:0] portFault;
  int err_count = 0, tests_run = 0, seed = 23688, cyc = 0, i;
  dio_wdog_regs #(.TANDEM(1), .TICKS_PER_SEC(TPS), .TICK_W(28)) dut_u (.sys_clk(sys_clk),
    .reset_n(reset_n), .swReset(swReset), .reqValid(reqValid), .reqWrite(reqWrite),
    .reqSpace(reqSpace), .reqAddr(reqAddr), .reqWdata(reqWdata), .respValid(respValid),
    .respError(respError), .respData(respData), .inPins(inPins), .fbPins(fbPins),
    .gateDrive(gateDrive), .identifyBlink(identifyBlink), .defaultMode(defaultMode),
    .portFault(portFault));
  // second bank reporting the raw active-low inputs
  dio_wdog_regs #(.TANDEM(0), .TICKS_PER_SEC(TPS), .TICK_W(28)) dut_t0 (.sys_clk(sys_clk),
    .reset_n(reset_n), .swReset(swReset), .reqValid(reqValid), .reqWrite(reqWrite),
    .reqSpace(reqSpace), .reqAddr(reqAddr), .reqWdata(reqWdata), .respValid(),
    .respError(), .respData(respData0), .inPins(inPins), .fbPins(fbPins),
    .gateDrive(), .identifyBlink(identifyBlink), .defaultMode(defaultMode),
    .portFault());
  dio_client cl_u (.sys_clk(sys_clk), .reqValid(reqValid), .reqWrite(reqWrite),
    .reqSpace(reqSpace), .reqAddr(reqAddr), .reqWdata(reqWdata), .respValid(respValid),
    .respError(respError), .respData(respData));
  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end
  task conclude;
    $display("mismatches %0d of %0d checks", err_count, tests_run);
    if (err_count == 0 && tests_run > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task chk(input logic [15:0] exp, input logic [15:0] got);
    tests_run++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED t=%0t exp=%h got=%h", $time, exp, got);
    end
  endtask
  task op(input logic w, input logic [1:0] sp, input logic [15:0] a, input logic [15:0] d,
          input logic [15:0] expD, input logic expE);
    cl_u.xfer(w, sp, a, d, rd, er);
    chk(expD, rd);
    chk({15'h0, expE}, {15'h0, er});
  endtask
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      err_count++;
      conclude();
    end
  end
  initial begin
    reset_n = 1'b0;
    swReset = 1'b0;
    identifyBlink = 1'b0;
    defaultMode = 1'b0;
    inPins = 12'h000;
    fbPins = 12'hfff;
    mGate = 12'h000;
    repeat (4) @(posedge sys_clk);
    #1 reset_n = 1'b1;
    for (i = 0; i < 12; i++) op(0, 2'h0, i, 0, 0, 0);
    op(0, 2'h3, 3, 0, 16'hffff, 0);
    op(0, 2'h3, 0, 0, 16'h0000, 0);
    for (i = 0; i < 12; i++) begin
      wd = $random(seed);
      mGate[i] = wd[i];
      op(1, 2'h0, i, wd, 0, 0);
    end
    chk({4'h0, mGate}, {4'h0, gateDrive});
    for (i = 0; i < 12; i++) op(0, 2'h0, i, 0, {4'h0, mGate} & (16'h1 << i), 0);
    op(1, 2'h1, 0, 1, 0, 1);
    op(0, 2'h0, 12, 0, 0, 1);
    op(0, 2'h2, 1, 0, 0, 1);
    op(1, 2'h3, 6, 0, 0, 1);
    @(posedge sys_clk) #1;
    fbPins = $random(seed);
    inPins = $random(seed);
    for (i = 0; i < 12; i++) begin
      op(0, 2'h1, i, 0, {4'h0, ~fbPins} & (16'h1 << i), 0);
      chk({4'h0, ~inPins} & (16'h1 << i), respData0);
    end
    // identify toggling sits outside, only its level is driven
    for (i = 0; i < 4; i++) begin
      {identifyBlink, defaultMode} = i[1:0];
      op(0, 2'h2, 0, 0, {1'b0, i[1:0], 13'h0}, 0);
    end
    {identifyBlink, defaultMode} = 2'b00;
    op(1, 2'h3, 3, 16'h000a, 0, 0);
    op(1, 2'h3, 1, 1, 0, 0);
    op(1, 2'h3, 2, 0, 0, 0);
    op(1, 2'h3, 0, 2, 0, 0);
    // port 1 has had its one tick, port 0 cannot have had two yet
    repeat (TPS) @(posedge sys_clk);
    #1 chk(16'h0002, {13'h0, portFault});
    repeat (2 * TPS + 5) @(posedge sys_clk);
    #1 mGate[3:0] = 4'ha;
    chk(16'h0003, {13'h0, portFault});
    chk({4'h0, mGate}, {4'h0, gateDrive});
    op(0, 2'h2, 0, 0, 16'h0003, 0);
    op(0, 2'h0, 1, 0, {4'h0, mGate} & 16'h0002, 0);
    chk(16'h0002, {13'h0, portFault});
    chk({4'h0, mGate}, {4'h0, gateDrive});
    op(1, 2'h3, 0, 16'hffff, 0, 0);
    @(posedge sys_clk) #1 swReset = 1'b1;
    @(posedge sys_clk) #1 swReset = 1'b0;
    chk(16'h0000, {13'h0, portFault});
    chk(16'h0000, {4'h0, gateDrive});
    op(0, 2'h3, 3, 0, 16'hffff, 0);
    op(0, 2'h3, 1, 0, 16'h0000, 0);
    conclude();
  end
endmodule
`default_nettype wire
